// ==== scsm_clock_mux.sv ====
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - transmit divider gives pll input clock over sixteen for fm codings
// - transmit divider gives pll input clock over thirty-two for nrzi
// - divider output replaces pll transmit output; pll receive use unchanged
// - with pll as transmit source, aux pin sees divider clock
// - two-bit field picks receive clock: main, aux, baud, pll receive
// - two-bit field picks transmit clock: main, aux, baud, pll transmit
// - aux pin input by default; output only if enabled and unused as source
// - aux output choice: oscillator, baud generator, pll receive, transmit clock
// - aux set to oscillator while amplifier off drives the pin high
// - receiver samples on rising edge of main clock pin via inversion
// - x1 async: wait one clock after first falling line edge
// - non-nrz coding only in x1 mode; other factors forced to nrz
// - oscillator enable turns amplifier on; main sources take oscillator
// - oscillator on in sync modes: no sync pulse, no external sync
// - oscillator on in async modes: search flag reads zero
module scsm_clock_mux
  import scsm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // clock pins
  input  wire logic        main_clock_pin,
  input  wire logic        osc_clk_i,
  output logic             osc_amp_en,
  input  wire logic        aux_clock_pin_i,
  output logic             aux_clock_pin_o,
  output logic             aux_clock_pin_oe,
  // sync pin and line data
  input  wire logic        sync_pin_i,
  output logic             sync_pin_o,
  output logic             sync_pin_oe,
  input  wire logic        rxd_pin,
  // on-chip clock sources
  input  wire logic        baud_clk,
  input  wire logic        pll_rx_clk,
  input  wire logic        pll_src_clk,
  // receiver and sync logic
  input  wire logic        sync_pulse,
  input  wire logic        hunt_flag,
  input  wire logic        char_done,
  // selected clocks and status
  output logic             rx_clk,
  output logic             tx_clk,
  output logic             rx_sample,
  output logic             rx_assemble_start,
  output logic             search_flag,
  output logic [1:0]       line_coding_eff,
  output logic             ext_sync_en,
  output logic             pll_fm_mode
);
  scsm_state_t q;
  scsm_state_t d;
  scsm_div_if  div_bus ();

  logic [1:0] rx_src;
  logic [1:0] tx_src;
  logic [1:0] aux_sel;
  logic [1:0] factor;
  logic       osc_en;
  logic       aux_dir;
  logic       sync_mode;
  logic       main_eff;
  logic       aux_in;
  logic       rx_sel;
  logic       tx_sel;
  logic       aux_drive;
  logic       aux_val;
  logic       bus_req;
  logic       line_fall;
  logic [31:0] stat_word;

  scsm_tx_divider u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .div     (div_bus.divider)
  );

  assign osc_en    = q.cmc[CMC_OSC_EN];
  assign rx_src    = q.cmc[CMC_RX_SRC_LSB +: 2];
  assign tx_src    = q.cmc[CMC_TX_SRC_LSB +: 2];
  assign aux_dir   = q.cmc[CMC_AUX_DIR];
  assign aux_sel   = q.cmc[CMC_AUX_SEL_LSB +: 2];
  assign factor    = q.cfg[CFG_FACTOR_LSB +: 2];
  assign sync_mode = q.cfg[CFG_SYNC_MODE];

  // coding other than nrz only honoured at x1
  assign line_coding_eff = (factor == FACTOR_X1) ? q.cfg[CFG_CODE_LSB +: 2]
                                                 : CODE_NRZ;
  assign pll_fm_mode     = q.cfg[CFG_PLL_FM];
  assign ext_sync_en     = q.cfg[CFG_EXT_SYNC] & sync_mode & ~osc_en;

  // divider runs on edges of the pll input clock
  assign div_bus.src_edge = pll_src_clk & ~q.pll_src_prev;
  assign div_bus.by32     = (line_coding_eff == CODE_NRZI) ||
                            (line_coding_eff == CODE_NRZ);

  assign main_eff = osc_en ? q.sync2[PIN_OSC] : q.sync2[PIN_MAIN];
  assign aux_in   = q.sync2[PIN_AUX];

  always_comb begin
    unique case (rx_src)
      SRC_MAIN: rx_sel = main_eff;
      SRC_AUX:  rx_sel = aux_in;
      SRC_BAUD: rx_sel = baud_clk;
      SRC_PLL:  rx_sel = pll_rx_clk;
    endcase
  end

  always_comb begin
    unique case (tx_src)
      SRC_MAIN: tx_sel = main_eff;
      SRC_AUX:  tx_sel = aux_in;
      SRC_BAUD: tx_sel = baud_clk;
      SRC_PLL:  tx_sel = div_bus.div_clk;
    endcase
  end

  assign aux_drive = aux_dir && (rx_src != SRC_AUX) && (tx_src != SRC_AUX);

  always_comb begin
    unique case (aux_sel)
      AUX_OSC:  aux_val = osc_en ? q.sync2[PIN_OSC] : 1'b1;
      AUX_TX:   aux_val = tx_sel;
      AUX_BAUD: aux_val = baud_clk;
      AUX_PLL:  aux_val = pll_rx_clk;
    endcase
  end

  assign bus_req   = avs_read | avs_write;
  // falling line edge, seen only past the second synchroniser stage
  assign line_fall = q.rxd_prev & ~q.sync2[PIN_RXD];

  always_comb begin
    stat_word                              = 32'h0000_0000;
    stat_word[STAT_AUX_OE]                 = q.aux_oe;
    stat_word[STAT_SEARCH]                 = q.search;
    stat_word[STAT_DIV_CLK]                = div_bus.div_clk;
    stat_word[STAT_CODE_LSB +: 2]          = line_coding_eff;
    stat_word[STAT_RX_BUSY]                = q.rx_st != RX_IDLE;
  end

  always_comb begin
    d              = q;
    d.sync1        = {rxd_pin, sync_pin_i, osc_clk_i, aux_clock_pin_i, main_clock_pin};
    d.sync2        = q.sync1;
    d.pll_src_prev = pll_src_clk;
    d.rxd_prev     = q.sync2[PIN_RXD];

    // bus slave: one wait cycle, then answer
    d.ack = bus_req & ~q.ack;
    if (bus_req && !q.ack) begin
      d.rdata = 32'h0000_0000;
      if (avs_read && avs_address == ADDR_CFG) begin
        d.rdata[7:0] = q.cfg;
      end
      if (avs_read && avs_address == ADDR_STAT) begin
        d.rdata = stat_word;
      end
    end
    if (avs_write && q.ack && avs_byteenable[0]) begin
      if (avs_address == ADDR_CMC) begin
        d.cmc = avs_writedata[7:0];
      end
      if (avs_address == ADDR_CFG) begin
        d.cfg = avs_writedata[7:0];
      end
    end

    // internal clocks are the inverse of the selected source level
    d.rx_clk    = ~rx_sel;
    d.tx_clk    = ~tx_sel;
    d.rx_sample = q.rx_clk & rx_sel;
    d.aux_oe    = aux_drive;
    d.aux_o     = aux_drive ? aux_val : 1'b0;

    d.sync_oe = sync_mode & ~osc_en & ~q.cfg[CFG_EXT_SYNC];
    d.sync_o  = d.sync_oe & sync_pulse;
    if (osc_en) begin
      d.search = sync_mode ? hunt_flag : 1'b0;
    end else begin
      d.search = sync_mode ? hunt_flag : q.sync2[PIN_SYNC];
    end

    // x1 async start: one receive clock after first falling edge
    d.rx_start = 1'b0;
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!sync_mode && factor == FACTOR_X1 && line_fall) begin
          d.rx_st = RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (q.rx_sample) begin
          d.rx_start = 1'b1;
          d.rx_st    = RX_ASSEMBLE;
        end
      end
      RX_ASSEMBLE: begin
        if (char_done || sync_mode || factor != FACTOR_X1) begin
          d.rx_st = RX_IDLE;
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase

    if (rst) begin
      d       = '0;
      d.cmc   = CMC_RST;
      d.cfg   = CFG_RST;
      d.rx_st = RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || ce) begin
      q <= d;
    end
  end

  // a frozen slave keeps the master waiting
  assign avs_waitrequest   = bus_req & ~(q.ack & ce);
  assign avs_readdata      = q.rdata;
  assign osc_amp_en        = osc_en;
  assign aux_clock_pin_o   = q.aux_o;
  assign aux_clock_pin_oe  = q.aux_oe;
  assign sync_pin_o        = q.sync_o;
  assign sync_pin_oe       = q.sync_oe;
  assign rx_clk            = q.rx_clk;
  assign tx_clk            = q.tx_clk;
  assign rx_sample         = q.rx_sample;
  assign rx_assemble_start = q.rx_start;
  assign search_flag       = q.search;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || !ce);

  property p_rx_baud;
    (rx_src == SRC_BAUD) |=> (rx_clk == !$past(baud_clk));
  endproperty
  a_rx_baud: assert property (p_rx_baud) else $error("receive clock not from baud");

  property p_tx_pll;
    (tx_src == SRC_PLL) |=> (tx_clk == !$past(div_bus.div_clk));
  endproperty
  a_tx_pll: assert property (p_tx_pll) else $error("transmit clock not from divider");

  property p_aux_dir;
    aux_clock_pin_oe |-> $past(aux_dir) && $past(rx_src) != SRC_AUX
                         && $past(tx_src) != SRC_AUX;
  endproperty
  a_aux_dir: assert property (p_aux_dir) else $error("aux pin driven while in use");

  property p_aux_osc_high;
    (aux_drive && aux_sel == AUX_OSC && !osc_en) |=> aux_clock_pin_o;
  endproperty
  a_aux_osc_high: assert property (p_aux_osc_high) else $error("aux not high");

  property p_aux_tx;
    (aux_drive && aux_sel == AUX_TX && tx_src == SRC_PLL)
      |=> (aux_clock_pin_o == $past(div_bus.div_clk));
  endproperty
  a_aux_tx: assert property (p_aux_tx) else $error("aux not divider clock");

  property p_sample_rise;
    (rx_src == SRC_MAIN && !osc_en && $past(rx_src) == SRC_MAIN && $past(!osc_en)
      && $rose(q.sync2[PIN_MAIN])) |=> rx_sample;
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("no sample on rise");

  property p_x1_wait;
    rx_assemble_start |-> $past(q.rx_st) == RX_WAIT && $past(q.rx_sample);
  endproperty
  a_x1_wait: assert property (p_x1_wait) else $error("start without waited clock");

  property p_coding;
    (factor != FACTOR_X1) |-> line_coding_eff == CODE_NRZ;
  endproperty
  a_coding: assert property (p_coding) else $error("coding not nrz");

  property p_div_fm;
    (line_coding_eff == CODE_FM0 || line_coding_eff == CODE_FM1) |-> !div_bus.by32;
  endproperty
  a_div_fm: assert property (p_div_fm) else $error("fm divider not sixteen");

  property p_sync_quiet;
    (osc_en && $past(osc_en)) |-> !sync_pin_oe && !ext_sync_en;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet) else $error("sync pin driven");

  property p_flag_zero;
    (osc_en && !sync_mode) |=> !search_flag;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("search flag not zero");

  property p_div_nrzi;
    (line_coding_eff == CODE_NRZI) |-> div_bus.by32;
  endproperty
  a_div_nrzi: assert property (p_div_nrzi) else $error("nrzi divider not thirty-two");

  property p_rx_pll;
    (rx_src == SRC_PLL) |=> (rx_clk == !$past(pll_rx_clk));
  endproperty
  a_rx_pll: assert property (p_rx_pll) else $error("receive clock not from pll");

  property p_tx_baud;
    (tx_src == SRC_BAUD) |=> (tx_clk == !$past(baud_clk));
  endproperty
  a_tx_baud: assert property (p_tx_baud) else $error("transmit clock not from baud");

  property p_aux_input;
    !aux_dir |=> !aux_clock_pin_oe;
  endproperty
  a_aux_input: assert property (p_aux_input) else $error("aux pin driven by default");

  property p_aux_baud;
    (aux_drive && aux_sel == AUX_BAUD) |=> (aux_clock_pin_o == $past(baud_clk));
  endproperty
  a_aux_baud: assert property (p_aux_baud) else $error("aux not baud clock");

  property p_aux_pll;
    (aux_drive && aux_sel == AUX_PLL) |=> (aux_clock_pin_o == $past(pll_rx_clk));
  endproperty
  a_aux_pll: assert property (p_aux_pll) else $error("aux not pll receive clock");

  property p_rx_osc;
    (osc_en && rx_src == SRC_MAIN) |=> (rx_clk == !$past(q.sync2[PIN_OSC]));
  endproperty
  a_rx_osc: assert property (p_rx_osc) else $error("main source not oscillator");

  c_aux_out:  cover property (aux_clock_pin_oe && aux_sel == AUX_PLL);
  c_x1_start: cover property (rx_assemble_start);
  c_osc_main: cover property (osc_en && rx_src == SRC_MAIN && rx_sample);
  c_div_nrzi: cover property (div_bus.by32 && div_bus.src_edge && tx_src == SRC_PLL);
endmodule

// ==== scsm_div_if.sv ====
`timescale 1ns/1ps
interface scsm_div_if;
  logic src_edge;
  logic by32;
  logic div_clk;

  modport ctrl (
    output src_edge,
    output by32,
    input  div_clk
  );

  modport divider (
    input  src_edge,
    input  by32,
    output div_clk
  );
endinterface

// ==== scsm_far_model.sv ====
`timescale 1ns/1ps
module scsm_far_model (
  // clock
  input  wire logic clk_sys,
  // levels asked for by the bench
  input  wire logic main_lvl,
  input  wire logic rxd_lvl,
  input  wire logic sync_lvl,
  input  wire logic aux_lvl,
  // device side of the pins
  input  wire logic osc_amp_en,
  input  wire logic aux_o,
  input  wire logic aux_oe,
  output logic      main_clock_pin,
  output logic      osc_clk_i,
  output logic      rxd_pin,
  output logic      sync_pin_i,
  output logic      aux_clock_pin_i
);
  logic [1:0] xtal_q = 2'h0;

  // crystal swings only while the amplifier is on
  always @(posedge clk_sys) begin
    xtal_q         <= osc_amp_en ? xtal_q + 2'h1 : 2'h0;
    osc_clk_i      <= osc_amp_en ? xtal_q[1] : 1'b0;
    main_clock_pin <= main_lvl;
    rxd_pin        <= rxd_lvl;
    sync_pin_i     <= sync_lvl;
  end

  // device wins the wire while it drives
  assign aux_clock_pin_i = aux_oe ? aux_o : aux_lvl;
endmodule

// ==== scsm_pkg.sv ====
package scsm_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_CMC  = 4'h0;
  localparam logic [3:0] ADDR_CFG  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // clock_mode_control fields
  localparam int CMC_OSC_EN      = 7;
  localparam int CMC_RX_SRC_LSB  = 5;
  localparam int CMC_TX_SRC_LSB  = 3;
  localparam int CMC_AUX_DIR     = 2;
  localparam int CMC_AUX_SEL_LSB = 0;
  localparam logic [7:0] CMC_RST = 8'h00;

  // coding/mode configuration fields
  localparam int CFG_PLL_FM     = 0;
  localparam int CFG_CODE_LSB   = 1;
  localparam int CFG_FACTOR_LSB = 3;
  localparam int CFG_SYNC_MODE  = 5;
  localparam int CFG_EXT_SYNC   = 6;
  localparam logic [7:0] CFG_RST = 8'h00;

  // status fields
  localparam int STAT_AUX_OE   = 0;
  localparam int STAT_SEARCH   = 1;
  localparam int STAT_DIV_CLK  = 2;
  localparam int STAT_CODE_LSB = 3;
  localparam int STAT_RX_BUSY  = 5;

  // clock source field encodings
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_AUX  = 2'h1;
  localparam logic [1:0] SRC_BAUD = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;

  // auxiliary pin output selections
  localparam logic [1:0] AUX_OSC  = 2'h0;
  localparam logic [1:0] AUX_TX   = 2'h1;
  localparam logic [1:0] AUX_BAUD = 2'h2;
  localparam logic [1:0] AUX_PLL  = 2'h3;

  // line codings and clock factors
  localparam logic [1:0] CODE_NRZ  = 2'h0;
  localparam logic [1:0] CODE_NRZI = 2'h1;
  localparam logic [1:0] CODE_FM1  = 2'h2;
  localparam logic [1:0] CODE_FM0  = 2'h3;
  localparam logic [1:0] FACTOR_X1 = 2'h0;

  // transmit divider half periods less one, in source edges
  localparam logic [3:0] DIV_HALF_FM   = 4'h7;
  localparam logic [3:0] DIV_HALF_NRZI = 4'hF;

  // synchronised pin indices
  localparam int PIN_MAIN = 0;
  localparam int PIN_AUX  = 1;
  localparam int PIN_OSC  = 2;
  localparam int PIN_SYNC = 3;
  localparam int PIN_RXD  = 4;
  localparam int PIN_N    = 5;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_WAIT,
    RX_ASSEMBLE
  } scsm_rx_st_t;

  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic             pll_src_prev;
    logic             rxd_prev;
    logic [7:0]       cmc;
    logic [7:0]       cfg;
    logic             ack;
    logic [31:0]      rdata;
    logic             rx_clk;
    logic             tx_clk;
    logic             aux_o;
    logic             aux_oe;
    logic             sync_o;
    logic             sync_oe;
    logic             search;
    logic             rx_sample;
    logic             rx_start;
    scsm_rx_st_t      rx_st;
  } scsm_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       out;
  } scsm_div_state_t;

endpackage

// ==== scsm_tx_divider.sv ====
`timescale 1ns/1ps
module scsm_tx_divider
  import scsm_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   ce,
  // control side
  scsm_div_if.divider div
);
  scsm_div_state_t q;
  scsm_div_state_t d;
  logic [3:0]      half;

  always_comb begin
    d    = q;
    half = div.by32 ? DIV_HALF_NRZI : DIV_HALF_FM;
    if (div.src_edge) begin
      if (q.cnt >= half) begin
        d.cnt = 4'h0;
        d.out = ~q.out;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || ce) begin
      q <= d;
    end
  end

  assign div.div_clk = q.out;

  property p_div_steady;
    @(posedge clk_sys) disable iff (rst || !ce)
      (ce && !div.src_edge) |=> $stable(q.out);
  endproperty
  a_div_steady: assert property (p_div_steady) else $error("divider moved without source edge");
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import scsm_pkg::*;
  logic        clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic        avs_waitrequest, main_lvl = 1'b0, rxd_lvl = 1'b1, sync_lvl = 1'b0;
  logic        aux_lvl = 1'b0, baud_clk = 1'b0, pll_rx_clk = 1'b0, pll_src_clk = 1'b0;
  logic        pll_run = 1'b0, sync_pulse = 1'b0, hunt_flag = 1'b0, char_done = 1'b0;
  logic        main_clock_pin, osc_clk_i, osc_amp_en, aux_clock_pin_i, aux_clock_pin_o;
  logic        aux_clock_pin_oe, sync_pin_i, sync_pin_o, sync_pin_oe, rxd_pin, v0, v1;
  logic        rx_clk, tx_clk, rx_sample, rx_assemble_start, search_flag, ext_sync_en;
  logic        pll_fm_mode, last_smp = 1'b0, ce = 1'b1;
  logic [1:0]  line_coding_eff;
  int          miscompares = 0, samples_checked = 0, n, p, k, j, a, b;
  int          n_smp = 0, n_st = 0, n_bad = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pll_run) pll_src_clk <= ~pll_src_clk;
  always @(posedge clk_sys) begin
    n_smp    <= n_smp + int'(rx_sample === 1'b1);
    n_st     <= n_st + int'(rx_assemble_start === 1'b1);
    n_bad    <= n_bad + int'(rx_assemble_start === 1'b1 && last_smp !== 1'b1);
    last_smp <= rx_sample;
  end

  scsm_clock_mux dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .main_clock_pin(main_clock_pin),
    .osc_clk_i(osc_clk_i), .osc_amp_en(osc_amp_en), .aux_clock_pin_i(aux_clock_pin_i),
    .aux_clock_pin_o(aux_clock_pin_o), .aux_clock_pin_oe(aux_clock_pin_oe),
    .sync_pin_i(sync_pin_i), .sync_pin_o(sync_pin_o), .sync_pin_oe(sync_pin_oe),
    .rxd_pin(rxd_pin), .baud_clk(baud_clk), .pll_rx_clk(pll_rx_clk),
    .pll_src_clk(pll_src_clk), .sync_pulse(sync_pulse), .hunt_flag(hunt_flag),
    .char_done(char_done), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_sample(rx_sample),
    .rx_assemble_start(rx_assemble_start), .search_flag(search_flag),
    .line_coding_eff(line_coding_eff), .ext_sync_en(ext_sync_en), .pll_fm_mode(pll_fm_mode)
  );

  scsm_far_model far_u (
    .clk_sys(clk_sys), .main_lvl(main_lvl), .rxd_lvl(rxd_lvl), .sync_lvl(sync_lvl),
    .aux_lvl(aux_lvl), .osc_amp_en(osc_amp_en), .aux_o(aux_clock_pin_o),
    .aux_oe(aux_clock_pin_oe), .main_clock_pin(main_clock_pin), .osc_clk_i(osc_clk_i),
    .rxd_pin(rxd_pin), .sync_pin_i(sync_pin_i), .aux_clock_pin_i(aux_clock_pin_i)
  );

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [7:0] d);
    int t;
    avs_address   <= ad;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  function automatic logic [7:0] cmc(logic o, logic [1:0] r, logic [1:0] t, logic d,
                                     logic [1:0] s);
    return {o, r, t, d, s};
  endfunction

  function automatic logic [7:0] cfg(logic f, logic [1:0] c, logic [1:0] x, logic s,
                                     logic e);
    return {1'b0, e, s, x, c, f};
  endfunction

  // cycles between two rises of tx clock (s=0) or aux pin (s=1)
  task automatic period(input int s, output int pr);
    logic v, l;
    int r;
    r = 0;
    pr = 0;
    l = 1'b1;
    while (r < 2 && pr < 400) begin
      @(negedge clk_sys);
      v = s ? aux_clock_pin_o : tx_clk;
      pr++;
      if (v === 1'b1 && l === 1'b0) begin
        r++;
        if (r == 1) pr = 0;
      end
      l = v;
    end
    @(posedge clk_sys);
  endtask

  task automatic toggles(output int t);
    logic l;
    t = 0;
    @(negedge clk_sys);
    l = rx_clk;
    repeat (40) begin
      @(negedge clk_sys);
      if (rx_clk !== l) t++;
      l = rx_clk;
    end
    @(posedge clk_sys);
  endtask

  initial begin
    #500_000;
    miscompares++;
    finish_test();
  end

  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(3);
    chk(osc_amp_en, CMC_RST[CMC_OSC_EN]);
    chk(aux_clock_pin_oe, 1'b0);
    chk(pll_fm_mode, CFG_RST[CFG_PLL_FM]);
    bus(1, ADDR_CFG, 8'h5A);
    bus(0, ADDR_CFG, 8'h00);
    chk(rd, 32'h0000_005A);
    chk(line_coding_eff, CODE_NRZ);
    bus(1, 4'hC, 8'hFF);
    bus(0, 4'hC, 8'h00);
    chk(rd, 32'h0000_0000);
    avs_byteenable <= 4'h0;
    bus(1, ADDR_CFG, 8'h00);
    avs_byteenable <= 4'hF;
    bus(1, ADDR_CMC, 8'h1B);
    bus(0, ADDR_CMC, 8'h00);
    chk(rd, 32'h0000_0000);
    bus(0, ADDR_CFG, 8'h00);
    chk(rd, 32'h0000_005A);
    for (k = 0; k < 4; k++) for (j = 0; j < 2; j++) begin
      bus(1, ADDR_CFG, cfg(0, k[1:0], j[1:0], 0, 0));
      chk(line_coding_eff, j == 0 ? k[1:0] : CODE_NRZ);
    end
    for (k = 0; k < 4; k++) for (j = 0; j < 2; j++) begin
      bus(1, ADDR_CMC, cmc(0, k[1:0], k[1:0], 0, AUX_OSC));
      main_lvl   <= (k == 0) ~^ j[0];
      aux_lvl    <= (k == 1) ~^ j[0];
      baud_clk   <= (k == 2) ~^ j[0];
      pll_rx_clk <= (k == 3) ~^ j[0];
      cyc(8);
      chk(rx_clk, !j[0]);
      if (k < 3) chk(tx_clk, !j[0]);
    end
    ce         <= 1'b0;
    pll_rx_clk <= 1'b0;
    cyc(6);
    chk(rx_clk, 1'b0);
    ce <= 1'b1;
    cyc(3);
    chk(rx_clk, 1'b1);
    pll_run <= 1'b1;
    for (k = 1; k < 4; k++) begin
      bus(1, ADDR_CFG, cfg(0, k[1:0], FACTOR_X1, 0, 0));
      bus(1, ADDR_CMC, cmc(0, SRC_BAUD, SRC_PLL, 1, AUX_TX));
      period(0, p);
      chk(p, k == 1 ? 64 : 32);
      period(1, p);
      chk(p, k == 1 ? 64 : 32);
    end
    pll_run <= 1'b0;
    bus(1, ADDR_CFG, cfg(1, CODE_NRZ, FACTOR_X1, 0, 0));
    chk(pll_fm_mode, 1'b1);
    chk(line_coding_eff, CODE_NRZ);
    for (k = 0; k < 4; k++) begin
      bus(1, ADDR_CMC, cmc(0, k == 0 ? SRC_AUX : SRC_BAUD, k == 1 ? SRC_AUX : SRC_BAUD,
                           k != 2, AUX_BAUD));
      cyc(4);
      chk(aux_clock_pin_oe, k == 3);
      bus(0, ADDR_STAT, 8'h00);
      chk(rd[STAT_AUX_OE], k == 3);
    end
    for (k = 1; k < 4; k++) begin
      bus(1, ADDR_CMC, cmc(0, SRC_PLL, SRC_BAUD, 1, k[1:0]));
      for (j = 0; j < 2; j++) begin
        baud_clk   <= (k != 3) & j[0];
        pll_rx_clk <= (k == 3) & j[0];
        cyc(6);
        if (j == 0) v0 = aux_clock_pin_o;
        else v1 = aux_clock_pin_o;
      end
      chk(v1, !v0);
    end
    bus(1, ADDR_CMC, cmc(0, SRC_BAUD, SRC_BAUD, 1, AUX_OSC));
    cyc(6);
    chk(aux_clock_pin_o, 1'b1);
    bus(1, ADDR_CMC, cmc(1, SRC_BAUD, SRC_BAUD, 0, AUX_OSC));
    cyc(20);
    bus(1, ADDR_CMC, cmc(1, SRC_MAIN, SRC_BAUD, 0, AUX_OSC));
    toggles(n);
    chk(osc_amp_en, 1'b1);
    chk(n > 4, 1'b1);
    bus(1, ADDR_CMC, cmc(0, SRC_MAIN, SRC_BAUD, 0, AUX_OSC));
    toggles(n);
    chk(n, 0);
    sync_pulse <= 1'b1;
    bus(1, ADDR_CFG, cfg(0, CODE_NRZ, FACTOR_X1, 1, 0));
    cyc(2);
    chk(sync_pin_o, 1'b1);
    bus(1, ADDR_CFG, cfg(0, CODE_NRZ, FACTOR_X1, 1, 1));
    chk(ext_sync_en, 1'b1);
    bus(1, ADDR_CMC, cmc(1, SRC_BAUD, SRC_BAUD, 0, AUX_OSC));
    cyc(4);
    chk(ext_sync_en, 1'b0);
    bus(1, ADDR_CFG, cfg(0, CODE_NRZ, FACTOR_X1, 1, 0));
    cyc(2);
    chk(sync_pin_oe, 1'b0);
    sync_pulse <= 1'b0;
    bus(1, ADDR_CFG, cfg(0, CODE_NRZ, FACTOR_X1, 0, 0));
    for (j = 0; j < 4; j++) begin
      if (j == 2) bus(1, ADDR_CMC, cmc(0, SRC_BAUD, SRC_BAUD, 0, AUX_OSC));
      sync_lvl <= j[0];
      cyc(6);
      if (j < 2) chk(search_flag, 1'b0);
      else if (j == 2) v0 = search_flag;
      else chk(search_flag, !v0);
    end
    bus(1, ADDR_CMC, cmc(0, SRC_MAIN, SRC_BAUD, 0, AUX_OSC));
    main_lvl <= 1'b0;
    rxd_lvl  <= 1'b1;
    cyc(8);
    a = n_smp;
    b = n_st;
    rxd_lvl <= 1'b0;
    cyc(10);
    chk(n_st - b, 0);
    chk(n_smp - a, 0);
    main_lvl <= 1'b1;
    cyc(8);
    chk(n_smp - a, 1);
    chk(n_st - b, 1);
    main_lvl <= 1'b0;
    cyc(8);
    chk(n_smp - a, 1);
    chk(n_bad, 0);
    char_done <= 1'b1;
    cyc(2);
    char_done <= 1'b0;
    finish_test();
  end
endmodule
